/* rtl/bfie_pkg.sv */
package bfie_pkg;
  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int WORD_W = 16;
  localparam int WIN_W = 32;
  localparam int REG8_W = 8;
  localparam int CODE_W = 4;
  localparam int ADDR_W = 20;
  localparam int SEG_SHIFT = 4;
  // ----------------------------------------------------------------
  // Field and pointer constants
  // ----------------------------------------------------------------
  localparam logic [REG8_W-1:0] CODE_MASK = 8'h0F;
  localparam logic [15:0] INDEX_STEP = 16'h0002;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] LAST_BIT = 5'h0F;
  localparam logic [WORD_W-1:0] ACC_RST = 16'h0000;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {BFIE_IDLE, BFIE_RD0, BFIE_RD1, BFIE_WR0, BFIE_WR1, BFIE_FIN} bfie_state_e;
endpackage : bfie_pkg

/* rtl/bfie_core.sv */
`timescale 1ns/100ps
// Contract
// - Insert stores low accumulator bits at segment-one:dest
// - Insert advances dest index and offset past field
// - Only low four offset bits are used
// - Length code means length minus one
// - Register length uses only low four bits
// - Fields crossing word boundary touch both words
// - Immediate form takes four-bit length code
// - Extract reads at segment-zero:source index
// - Extract right-aligns field, zero-fills upper bits
// - Extract advances source index and offset
module bfie_core (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic START,
  input wire logic OP_PULL,
  input wire logic LEN_FROM_IMM,
  input wire logic [7:0] LEN_REG,
  input wire logic [3:0] SHORT_IMMEDIATE_LENGTH,
  input wire logic [7:0] OFFSET_REG,
  input wire logic [15:0] ACCUMULATOR_WORD,
  input wire logic [15:0] DATA_SEGMENT_ZERO,
  input wire logic [15:0] DATA_SEGMENT_ONE,
  input wire logic [15:0] SOURCE_INDEX,
  input wire logic [15:0] DEST_INDEX,
  input wire logic [15:0] MEM_RDATA,
  input wire logic MEM_ACK,
  output logic BUSY,
  output logic DONE,
  output logic MEM_REQ,
  output logic MEM_WE,
  output logic [19:0] MEM_ADDR,
  output logic [15:0] MEM_WDATA,
  output logic [15:0] ACC_RESULT,
  output logic ACC_WE,
  output logic [7:0] OFFSET_RESULT,
  output logic [15:0] INDEX_RESULT,
  output logic SRC_INDEX_WE,
  output logic DST_INDEX_WE,
  output logic FLAGS_UNDEF
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Mask of code+1 ones, low aligned
  function automatic logic [31:0] len_mask(input logic [3:0] code);
    len_mask = 32'h0000FFFF >> (4'hF - code);
  endfunction : len_mask

  // Segment base times sixteen plus index
  function automatic logic [19:0] phys_addr(input logic [15:0] seg, input logic [15:0] idx);
    phys_addr = {seg, 4'h0} + {4'h0, idx};
  endfunction : phys_addr

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_sync_reg;

  // Two stages so release is clean against CLK_SYS
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  bfie_pkg::bfie_state_e state_reg, state_next;
  logic pull_reg, pull_next;
  logic [3:0] off_reg, off_next;
  logic [3:0] code_reg, code_next;
  logic [15:0] acc_reg, acc_next;
  logic [15:0] seg_reg, seg_next;
  logic [15:0] idx_reg, idx_next;
  logic [15:0] w0_reg, w0_next;
  logic [15:0] w1_reg, w1_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;
  logic req_reg, req_next;
  logic we_reg, we_next;
  logic [19:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic [15:0] accr_reg, accr_next;
  logic accwe_reg, accwe_next;
  logic [7:0] offr_reg, offr_next;
  logic [15:0] idxr_reg, idxr_next;
  logic srcwe_reg, srcwe_next;
  logic dstwe_reg, dstwe_next;
  logic flg_reg, flg_next;

  logic [4:0] end_bit;
  logic [4:0] bit_sum;
  logic crosses;
  logic [31:0] window;
  logic [31:0] place_mask;
  logic [31:0] merged;
  logic [31:0] pulled;

  // Field geometry over a two-word window
  always_comb begin
    end_bit = {1'b0, off_reg} + {1'b0, code_reg};
    bit_sum = end_bit + 5'h01;
    crosses = end_bit > bfie_pkg::LAST_BIT;
    window = {w1_reg, w0_reg};
    place_mask = len_mask(code_reg) << off_reg;
    merged = (window & ~place_mask) | (({16'h0000, acc_reg} << off_reg) & place_mask);
    pulled = (window >> off_reg) & len_mask(code_reg);
  end

  // Next-state and output computation
  always_comb begin
    state_next = state_reg;
    pull_next = pull_reg;
    off_next = off_reg;
    code_next = code_reg;
    acc_next = acc_reg;
    seg_next = seg_reg;
    idx_next = idx_reg;
    w0_next = w0_reg;
    w1_next = w1_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    req_next = req_reg;
    we_next = we_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    accr_next = accr_reg;
    accwe_next = 1'b0;
    offr_next = offr_reg;
    idxr_next = idxr_reg;
    srcwe_next = 1'b0;
    dstwe_next = 1'b0;
    flg_next = 1'b0;
    case (state_reg)
      bfie_pkg::BFIE_IDLE: begin
        if (START) begin
          // Upper nibbles ignored; software is expected to clear them
          off_next = OFFSET_REG[3:0];
          code_next = LEN_FROM_IMM ? SHORT_IMMEDIATE_LENGTH : LEN_REG[3:0];
          pull_next = OP_PULL;
          acc_next = ACCUMULATOR_WORD;
          seg_next = OP_PULL ? DATA_SEGMENT_ZERO : DATA_SEGMENT_ONE;
          idx_next = OP_PULL ? SOURCE_INDEX : DEST_INDEX;
          w1_next = 16'h0000;
          addr_next = OP_PULL ? phys_addr(DATA_SEGMENT_ZERO, SOURCE_INDEX) : phys_addr(DATA_SEGMENT_ONE, DEST_INDEX);
          req_next = 1'b1;
          we_next = 1'b0;
          busy_next = 1'b1;
          state_next = bfie_pkg::BFIE_RD0;
        end
      end
      bfie_pkg::BFIE_RD0: begin
        if (MEM_ACK) begin
          w0_next = MEM_RDATA;
          req_next = 1'b0;
          state_next = pull_reg ? bfie_pkg::BFIE_FIN : bfie_pkg::BFIE_WR0;
          // Second word only when the field spills over
          if (crosses) begin
            req_next = 1'b1;
            addr_next = phys_addr(seg_reg, idx_reg + bfie_pkg::INDEX_STEP);
            state_next = bfie_pkg::BFIE_RD1;
          end
        end
      end
      bfie_pkg::BFIE_RD1: begin
        if (MEM_ACK) begin
          w1_next = MEM_RDATA;
          req_next = 1'b0;
          state_next = pull_reg ? bfie_pkg::BFIE_FIN : bfie_pkg::BFIE_WR0;
        end
      end
      bfie_pkg::BFIE_WR0: begin
        // Read-modify-write keeps bits outside the field intact
        if (!req_reg) begin
          req_next = 1'b1;
          we_next = 1'b1;
          addr_next = phys_addr(seg_reg, idx_reg);
          wdata_next = merged[15:0];
        end else if (MEM_ACK) begin
          req_next = 1'b0;
          we_next = 1'b0;
          state_next = crosses ? bfie_pkg::BFIE_WR1 : bfie_pkg::BFIE_FIN;
        end
      end
      bfie_pkg::BFIE_WR1: begin
        if (!req_reg) begin
          req_next = 1'b1;
          we_next = 1'b1;
          addr_next = phys_addr(seg_reg, idx_reg + bfie_pkg::INDEX_STEP);
          wdata_next = merged[31:16];
        end else if (MEM_ACK) begin
          req_next = 1'b0;
          we_next = 1'b0;
          state_next = bfie_pkg::BFIE_FIN;
        end
      end
      bfie_pkg::BFIE_FIN: begin
        // Pointer wraps at the word; index moves a whole word
        offr_next = {4'h0, bit_sum[3:0]};
        idxr_next = (bit_sum >= bfie_pkg::WORD_BITS) ? idx_reg + bfie_pkg::INDEX_STEP : idx_reg;
        srcwe_next = pull_reg;
        dstwe_next = !pull_reg;
        if (pull_reg) begin
          accr_next = pulled[15:0];
          accwe_next = 1'b1;
        end
        flg_next = 1'b1;
        done_next = 1'b1;
        busy_next = 1'b0;
        state_next = bfie_pkg::BFIE_IDLE;
      end
      default: begin
        state_next = bfie_pkg::BFIE_IDLE;
        busy_next = 1'b0;
        req_next = 1'b0;
        we_next = 1'b0;
      end
    endcase
  end

  // State registers
  always_ff @(posedge CLK_SYS or negedge rst_sync_reg) begin
    if (!rst_sync_reg) begin
      state_reg <= bfie_pkg::BFIE_IDLE;
      pull_reg <= 1'b0;
      off_reg <= 4'h0;
      code_reg <= 4'h0;
      acc_reg <= bfie_pkg::ACC_RST;
      seg_reg <= 16'h0000;
      idx_reg <= 16'h0000;
      w0_reg <= 16'h0000;
      w1_reg <= 16'h0000;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= 20'h00000;
      wdata_reg <= 16'h0000;
      accr_reg <= bfie_pkg::ACC_RST;
      accwe_reg <= 1'b0;
      offr_reg <= 8'h00;
      idxr_reg <= 16'h0000;
      srcwe_reg <= 1'b0;
      dstwe_reg <= 1'b0;
      flg_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pull_reg <= pull_next;
      off_reg <= off_next;
      code_reg <= code_next;
      acc_reg <= acc_next;
      seg_reg <= seg_next;
      idx_reg <= idx_next;
      w0_reg <= w0_next;
      w1_reg <= w1_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
      req_reg <= req_next;
      we_reg <= we_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      accr_reg <= accr_next;
      accwe_reg <= accwe_next;
      offr_reg <= offr_next;
      idxr_reg <= idxr_next;
      srcwe_reg <= srcwe_next;
      dstwe_reg <= dstwe_next;
      flg_reg <= flg_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs, all straight from flops
  // ----------------------------------------------------------------
  assign BUSY = busy_reg;
  assign DONE = done_reg;
  assign MEM_REQ = req_reg;
  assign MEM_WE = we_reg;
  assign MEM_ADDR = addr_reg;
  assign MEM_WDATA = wdata_reg;
  assign ACC_RESULT = accr_reg;
  assign ACC_WE = accwe_reg;
  assign OFFSET_RESULT = offr_reg;
  assign INDEX_RESULT = idxr_reg;
  assign SRC_INDEX_WE = srcwe_reg;
  assign DST_INDEX_WE = dstwe_reg;
  assign FLAGS_UNDEF = flg_reg;
endmodule : bfie_core

/* dv/bfie_mem.sv */
`timescale 1ns/100ps
module bfie_mem (
  input wire logic CLK_SYS,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [19:0] MEM_ADDR,
  input wire logic [15:0] MEM_WDATA,
  input wire logic [3:0] ACK_WAIT,
  output logic [15:0] MEM_RDATA,
  output logic MEM_ACK
);
  logic [15:0] mem [32];
  int wait_cnt = 0;
  initial begin
    MEM_ACK = 1'h0;
    MEM_RDATA = 16'h0000;
  end
  // Word store; idle read data toggles so stale values never look valid
  always @(posedge CLK_SYS) begin
    MEM_ACK <= 1'h0;
    MEM_RDATA <= ~MEM_RDATA;
    if (MEM_REQ && !MEM_ACK) begin
      if (wait_cnt < ACK_WAIT) wait_cnt <= wait_cnt + 1;
      else begin
        wait_cnt <= 0;
        MEM_ACK <= 1'h1;
        if (MEM_WE) mem[MEM_ADDR[5:1]] <= MEM_WDATA;
        else MEM_RDATA <= mem[MEM_ADDR[5:1]];
      end
    end
  end
endmodule : bfie_mem

/* dv/bfie_chk.sv */
`timescale 1ns/100ps
module bfie_chk (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic OP_PULL,
  input wire logic LEN_FROM_IMM,
  input wire logic [7:0] LEN_REG,
  input wire logic [3:0] SHORT_IMMEDIATE_LENGTH,
  input wire logic [7:0] OFFSET_REG,
  input wire logic [15:0] DATA_SEGMENT_ZERO,
  input wire logic [15:0] DATA_SEGMENT_ONE,
  input wire logic [15:0] SOURCE_INDEX,
  input wire logic [15:0] DEST_INDEX,
  input wire logic MEM_ACK,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic MEM_REQ,
  input wire logic MEM_WE,
  input wire logic [19:0] MEM_ADDR,
  input wire logic [15:0] ACC_RESULT,
  input wire logic [7:0] OFFSET_RESULT,
  input wire logic [15:0] INDEX_RESULT,
  input wire logic SRC_INDEX_WE,
  input wire logic DST_INDEX_WE,
  input wire logic FLAGS_UNDEF
);
  logic [3:0] code;
  logic [4:0] sum;
  logic [15:0] base_idx;
  logic [15:0] next_idx;
  logic [19:0] base_addr;
  logic [19:0] next_addr;
  // Operands are held by the caller until completion
  assign code = LEN_FROM_IMM ? SHORT_IMMEDIATE_LENGTH : LEN_REG[3:0];
  assign sum = {1'h0, OFFSET_REG[3:0]} + {1'h0, code} + 5'h01;
  // Second word of a spilling field; index wraps within sixteen bits
  assign base_idx = OP_PULL ? SOURCE_INDEX : DEST_INDEX;
  assign next_idx = base_idx + 16'h0002;
  assign base_addr = {(OP_PULL ? DATA_SEGMENT_ZERO : DATA_SEGMENT_ONE), 4'h0} + {4'h0, base_idx};
  assign next_addr = {(OP_PULL ? DATA_SEGMENT_ZERO : DATA_SEGMENT_ONE), 4'h0} + {4'h0, next_idx};
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  start_addr_a: assert property ($rose(BUSY) |-> MEM_REQ && !MEM_WE && MEM_ADDR ==
    ({4'h0, OP_PULL ? DATA_SEGMENT_ZERO : DATA_SEGMENT_ONE} << 4) + (OP_PULL ? SOURCE_INDEX : DEST_INDEX))
    else $error("first access address wrong");
  done_pulse_a: assert property (DONE |=> !DONE) else $error("done longer than one cycle");
  req_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE))
    else $error("request changed before ack");
  // A spilling first read chains straight into the next word; every other ack drops the request
  ack_drop_a: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ || (sum > 5'h10 && !MEM_WE &&
    $past(MEM_ADDR) == base_addr && MEM_ADDR == next_addr)) else $error("request held after ack");
  done_flags_a: assert property (DONE |-> FLAGS_UNDEF && !BUSY && SRC_INDEX_WE == OP_PULL &&
    DST_INDEX_WE == !OP_PULL) else $error("completion strobes wrong");
  new_offset_a: assert property (DONE |-> OFFSET_RESULT == {4'h0, sum[3:0]})
    else $error("new offset wrong");
  index_step_a: assert property (DONE |-> INDEX_RESULT == (OP_PULL ? SOURCE_INDEX : DEST_INDEX) +
    (sum[4] ? 16'h0002 : 16'h0000)) else $error("new index wrong");
  zero_fill_a: assert property (DONE && OP_PULL |-> (ACC_RESULT >> (code + 5'h01)) == 16'h0000)
    else $error("upper result bits not zero");
  pull_c: cover property (DONE && OP_PULL && sum[4]);
  place_c: cover property (DONE && !OP_PULL && sum[4]);
  write_c: cover property (MEM_REQ && MEM_WE && MEM_ACK);
endmodule : bfie_chk
bind bfie_core bfie_chk bfie_chk_i (.*);

/* dv/bfie_core_tb.sv */
`timescale 1ns/100ps
module bfie_core_tb;
  logic CLK_SYS = 0, RST_N = 0, START = 0, OP_PULL = 0, LEN_FROM_IMM = 0;
  logic [7:0] LEN_REG = 0, OFFSET_REG = 0, OFFSET_RESULT;
  logic [3:0] SHORT_IMMEDIATE_LENGTH = 0, ACK_WAIT = 0;
  // Distinct bases and indexes so a swapped operand shows; both still land on model words 2 and 3
  logic [15:0] ACCUMULATOR_WORD = 0, DATA_SEGMENT_ZERO = 16'h0010, DATA_SEGMENT_ONE = 16'h0050;
  logic [15:0] SOURCE_INDEX = 16'h0004, DEST_INDEX = 16'h0044;
  logic [15:0] MEM_RDATA, MEM_WDATA, ACC_RESULT, INDEX_RESULT;
  logic [19:0] MEM_ADDR;
  logic MEM_ACK, BUSY, DONE, MEM_REQ, MEM_WE, ACC_WE, SRC_INDEX_WE, DST_INDEX_WE, FLAGS_UNDEF;
  int n_errors = 0, total_checks = 0;
  bfie_core bfie_core_i (.*);
  bfie_mem bfie_mem_i (.*);
  initial forever #2.5 CLK_SYS = ~CLK_SYS;
  // Compare and count; four-state equality so unknowns fail
  task automatic check(string what, logic [19:0] seen, logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  // One operation; operands stay put until the next call so results can be checked
  task automatic run(logic p, logic i, logic [7:0] lr, logic [3:0] li, logic [7:0] off, logic [15:0] acc);
    int n;
    @(posedge CLK_SYS);
    OP_PULL <= p;
    LEN_FROM_IMM <= i;
    LEN_REG <= lr;
    SHORT_IMMEDIATE_LENGTH <= li;
    OFFSET_REG <= off;
    ACCUMULATOR_WORD <= acc;
    START <= 1'h1;
    @(posedge CLK_SYS);
    START <= 1'h0;
    for (n = 0; n < 100 && DONE !== 1'h1; n++) begin
      @(posedge CLK_SYS);
      #1;
    end
    check("done", n < 100, 1'h1);
  endtask : run
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_pull();
    bfie_mem_i.mem[2] = 16'h5555;
    bfie_mem_i.mem[3] = 16'h3333;
    run(1'h1, 1'h0, 8'h04, 4'hB, 8'h03, 16'h0000);
    check("acc", ACC_RESULT, 16'h000A);
    check("off", OFFSET_RESULT, 8'h08);
    check("idx", INDEX_RESULT, 16'h0004);
    check("we", {ACC_WE, SRC_INDEX_WE, FLAGS_UNDEF}, 3'h7);
    ACK_WAIT = 4'h3;
    run(1'h1, 1'h1, 8'h0B, 4'hC, 8'h08, 16'h0000);
    check("acc", ACC_RESULT, 16'h1355);
    check("off", OFFSET_RESULT, 8'h05);
    check("idx", INDEX_RESULT, 16'h0006);
  endtask : t_pull
  // Neighbouring bits are set so a clobbering write shows up
  task automatic t_place();
    bfie_mem_i.mem[2] = 16'h8007;
    bfie_mem_i.mem[3] = 16'hFFE0;
    ACK_WAIT = 4'h0;
    run(1'h0, 1'h0, 8'h04, 4'h1, 8'h03, 16'h5555);
    check("mem0", bfie_mem_i.mem[2], 16'h80AF);
    check("off", OFFSET_RESULT, 8'h08);
    check("idx", INDEX_RESULT, 16'h0044);
    check("we", DST_INDEX_WE, 1'h1);
    ACK_WAIT = 4'h2;
    run(1'h0, 1'h1, 8'h03, 4'hC, 8'h08, 16'h5555);
    check("mem0", bfie_mem_i.mem[2], 16'h55AF);
    check("mem1", bfie_mem_i.mem[3], 16'hFFF5);
    check("off", OFFSET_RESULT, 8'h05);
    check("idx", INDEX_RESULT, 16'h0046);
  endtask : t_place
  // Full word at bit 0 wraps exactly to 16; single bit at offset fourteen ends one below the top bit
  task automatic t_bounds();
    run(1'h1, 1'h1, 8'h00, 4'hF, 8'h00, 16'h0000);
    check("acc", ACC_RESULT, 16'h55AF);
    check("off", OFFSET_RESULT, 8'h00);
    check("idx", INDEX_RESULT, 16'h0006);
    run(1'h1, 1'h0, 8'h00, 4'h7, 8'h0E, 16'h0000);
    check("acc", ACC_RESULT, 16'h0001);
    check("off", OFFSET_RESULT, 8'h0F);
  endtask : t_bounds
  initial begin
    repeat (6) @(posedge CLK_SYS);
    RST_N <= 1'h1;
    repeat (3) @(posedge CLK_SYS);
    t_pull();
    t_place();
    t_bounds();
    stop_test();
  end
  // Whole run needs well under 300 cycles
  initial begin
    #5000;
    n_errors++;
    stop_test();
  end
endmodule : bfie_core_tb
